// ===== logic/tsq_core.sv
// Step queue command decoder and sequencer with APB register slave
//
// Implementation choices: the APB register port and the register addresses.
module tsq_core (
    input wire logic clk, // 250 MHz clock
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [15:0] trig_in, // Trigger inputs
    output logic [31:0] trig_out, // Trigger output pulses
    output logic [7:0] irq_req, // Interrupt request pulses
    output logic [15:0] strobe_out, // Strobe value
    output logic strobe_stb, // Strobe update pulse
    output logic [5:0] adc_channel_select, // ADC channel value
    output logic adc_chan_stb // ADC channel update pulse
);
    import tsq_pkg::*;

    //------------------------------------------------------------
    // Storage and state
    //------------------------------------------------------------
    tsq_state_t state_reg;
    logic [15:0] tgt_reg [TSQ_NTGT];
    logic [15:0] queue_reg [16];
    logic [4:0] qptr_reg;
    logic [4:0] qptr_next;
    logic [7:0] cmd_reg;
    logic [15:0] adj_reg;
    logic [15:0] hold_reg;
    logic [31:0] bte_reg;
    logic run_reg;
    logic swt_reg;
    logic sden_reg;
    logic [15:0] loop_reg [2];
    logic [15:0] tmr_reg;
    logic [15:0] dly_reg;
    logic [15:0] trig_prev_reg;
    logic swt_prev_reg;

    //------------------------------------------------------------
    // Decode
    //------------------------------------------------------------
    logic [3:0] op;
    logic [3:0] opt;
    logic [4:0] tgt5;
    logic busy;
    logic wr;
    logic is_wait;
    logic wait_hit;
    logic step_done;
    logic ljump;
    logic lsel;
    logic lat_lim;
    logic [2:0] tidx;

    assign op = cmd_reg[7:4];
    assign opt = cmd_reg[3:0];
    assign tgt5 = {cmd_reg[4], opt};
    assign busy = state_reg != TSQ_S_IDLE;
    assign wr = psel && penable && pwrite;
    assign ljump = cmd_reg[7:6] == 2'b11;
    assign lsel = cmd_reg[5];
    assign lat_lim = loop_reg[lsel] == tgt_reg[{2'b00, lsel}];
    assign tidx = opt[2:0];

    // Waiting steps: edge waits, timer waits and software trigger waits
    assign is_wait = op == TSQ_OP_WHI || op == TSQ_OP_WLO ||
        (op == TSQ_OP_CTRL && opt[3:2] == 2'b10);

    // Wait release conditions
    always_comb begin
        case (op)
            TSQ_OP_WHI: wait_hit = trig_in[opt] && !trig_prev_reg[opt];
            TSQ_OP_WLO: wait_hit = !trig_in[opt] && trig_prev_reg[opt];
            default: begin
                case (opt)
                    TSQ_CO_T0: wait_hit = tmr_reg == tgt_reg[2];
                    TSQ_CO_T1: wait_hit = tmr_reg == tgt_reg[3];
                    TSQ_CO_SWL: wait_hit = swt_reg;
                    default: wait_hit = swt_reg && !swt_prev_reg;
                endcase
            end
        endcase
    end

    assign step_done = (state_reg == TSQ_S_EXEC && !is_wait) ||
        (state_reg == TSQ_S_WAIT && wait_hit);

    // Next pointer at step completion
    always_comb begin
        qptr_next = qptr_reg + 5'h01;
        if (cmd_reg[7:5] == 3'b101) begin
            qptr_next = tgt5;
        end else if (ljump && !lat_lim) begin
            qptr_next = tgt5;
        end
    end

    //------------------------------------------------------------
    // Sequencer state machine
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= TSQ_S_IDLE;
        end else if (!run_reg) begin
            state_reg <= TSQ_S_IDLE;
        end else begin
            case (state_reg)
                TSQ_S_IDLE: state_reg <= TSQ_S_FETCH;
                TSQ_S_FETCH: state_reg <= TSQ_S_EXEC;
                TSQ_S_EXEC, TSQ_S_WAIT: begin
                    if (step_done) begin
                        state_reg <= (sden_reg && tgt_reg[4] != TSQ_RST16) ?
                            TSQ_S_DELAY : TSQ_S_FETCH;
                    end else begin
                        state_reg <= TSQ_S_WAIT;
                    end
                end
                TSQ_S_DELAY: begin
                    if (dly_reg >= tgt_reg[4]) begin
                        state_reg <= TSQ_S_FETCH;
                    end
                end
                default: state_reg <= TSQ_S_IDLE;
            endcase
        end
    end

    // Fetch the active byte: odd steps sit in the high byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_reg <= 8'h00;
        end else if (state_reg == TSQ_S_FETCH) begin
            cmd_reg <= qptr_reg[0] ? queue_reg[qptr_reg[4:1]][15:8] :
                queue_reg[qptr_reg[4:1]][7:0];
        end
    end

    // Queue pointer: software when idle, sequencer at step end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            qptr_reg <= 5'h00;
        end else if (step_done) begin
            qptr_reg <= qptr_next;
        end else if (wr && !busy && paddr == TSQ_OFS_QPTR) begin
            qptr_reg <= pwdata[4:0];
        end
    end

    // Loop counters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_reg[0] <= TSQ_RST16;
            loop_reg[1] <= TSQ_RST16;
        end else if (state_reg == TSQ_S_EXEC && ljump) begin
            if (lat_lim) begin
                loop_reg[lsel] <= TSQ_RST16;
            end else begin
                loop_reg[lsel] <= loop_reg[lsel] + 16'h0001;
            end
        end
    end

    // Timers, step delay and edge history
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_reg <= TSQ_RST16;
            dly_reg <= TSQ_RST16;
            trig_prev_reg <= TSQ_RST16;
            swt_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig_in;
            swt_prev_reg <= swt_reg;
            tmr_reg <= (state_reg == TSQ_S_WAIT) ? tmr_reg + 16'h0001 : TSQ_RST16;
            dly_reg <= (state_reg == TSQ_S_DELAY) ? dly_reg + 16'h0001 : 16'h0001;
        end
    end

    // Target registers: software writes when idle, add or copy when run
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < TSQ_NTGT; i++) begin
                tgt_reg[i] <= TSQ_RST16;
            end
        end else if (state_reg == TSQ_S_EXEC && op == TSQ_OP_ADD) begin
            if (tidx < 3'd6) begin
                if (!opt[3]) begin
                    tgt_reg[tidx] <= tgt_reg[tidx] + adj_reg;
                end else begin
                    tgt_reg[tidx] <= hold_reg;
                end
            end
        end else if (wr && !busy && paddr < TSQ_OFS_QPTR && paddr[1:0] == 2'b00) begin
            tgt_reg[paddr[4:2]] <= pwdata[15:0];
        end
    end

    // Queue storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                queue_reg[i] <= TSQ_RST16;
            end
        end else if (wr && !busy && paddr[7:6] == 2'b01 && paddr[1:0] == 2'b00) begin
            queue_reg[paddr[5:2]] <= pwdata[15:0];
        end
    end

    // Control, adjust, hold and broadcast mask
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_reg <= 1'b0;
            swt_reg <= 1'b0;
            sden_reg <= 1'b0;
            adj_reg <= TSQ_RST16;
            hold_reg <= TSQ_RST16;
            bte_reg <= TSQ_RST32;
        end else begin
            if (wr && paddr == TSQ_OFS_CTRL) begin
                run_reg <= pwdata[TSQ_CB_RUN];
                swt_reg <= pwdata[TSQ_CB_SWT];
            end
            if (state_reg == TSQ_S_EXEC && op == TSQ_OP_CTRL && opt == TSQ_CO_SDOFF) begin
                sden_reg <= 1'b0;
            end else if (state_reg == TSQ_S_EXEC && op == TSQ_OP_CTRL &&
                opt == TSQ_CO_SDON) begin
                sden_reg <= 1'b1;
            end else if (wr && !busy && paddr == TSQ_OFS_CTRL) begin
                sden_reg <= pwdata[TSQ_CB_SDEN];
            end
            if (wr && !busy && paddr == TSQ_OFS_ADJ) begin
                adj_reg <= pwdata[15:0];
            end
            if (wr && !busy && paddr == TSQ_OFS_HOLD) begin
                hold_reg <= pwdata[15:0];
            end
            if (wr && !busy && paddr == TSQ_OFS_BTE) begin
                bte_reg <= pwdata;
            end
        end
    end

    //------------------------------------------------------------
    // Step outputs from flip-flops: strobe and channel values hold, triggers, interrupts and update strobes are one-cycle pulses
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_out <= TSQ_RST32;
            irq_req <= 8'h00;
            strobe_out <= TSQ_RST16;
            strobe_stb <= 1'b0;
            adc_channel_select <= 6'h00;
            adc_chan_stb <= 1'b0;
        end else begin
            trig_out <= TSQ_RST32;
            irq_req <= 8'h00;
            strobe_stb <= 1'b0;
            adc_chan_stb <= 1'b0;
            if (state_reg == TSQ_S_EXEC) begin
                if (cmd_reg[7:5] == 3'b001) begin
                    strobe_out <= {11'h000, tgt5};
                    strobe_stb <= 1'b1;
                end else if (cmd_reg[7:5] == 3'b100) begin
                    trig_out[tgt5] <= 1'b1;
                end else if (op == TSQ_OP_IRQ && !opt[3]) begin
                    irq_req[opt[2:0]] <= 1'b1;
                end else if (op == TSQ_OP_CTRL) begin
                    case (opt)
                        TSQ_CO_SC0, TSQ_CO_SC1: begin
                            strobe_out <= tgt_reg[{2'b00, opt[0]}];
                            strobe_stb <= 1'b1;
                        end
                        TSQ_CO_SLIT: begin
                            strobe_out <= tgt_reg[TSQ_LIT];
                            strobe_stb <= 1'b1;
                            adc_channel_select <= tgt_reg[TSQ_LIT][5:0];
                            adc_chan_stb <= 1'b1;
                        end
                        TSQ_CO_BCAST: trig_out <= bte_reg;
                        default: ;
                    endcase
                end
            end
        end
    end

    //------------------------------------------------------------
    // APB slave: zero wait states, read data captured in setup
    //------------------------------------------------------------
    function automatic logic tsq_mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && (a <= TSQ_OFS_CNT || a[7:6] == 2'b01);
    endfunction

    assign pready = psel && penable;
    assign pslverr = psel && penable && !tsq_mapped(paddr);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= TSQ_RST32;
        end else if (psel && !penable) begin
            prdata <= TSQ_RST32;
            if (paddr[7:6] == 2'b01) begin
                prdata[15:0] <= queue_reg[paddr[5:2]];
            end else if (paddr < TSQ_OFS_QPTR) begin
                prdata[15:0] <= tgt_reg[paddr[4:2]];
            end else begin
                case (paddr)
                    TSQ_OFS_QPTR: prdata[4:0] <= qptr_reg;
                    TSQ_OFS_CTRL: begin
                        prdata[TSQ_CB_RUN] <= run_reg;
                        prdata[TSQ_CB_SWT] <= swt_reg;
                        prdata[TSQ_CB_SDEN] <= sden_reg;
                        prdata[TSQ_CB_BUSY] <= busy;
                    end
                    TSQ_OFS_ADJ: prdata[15:0] <= adj_reg;
                    TSQ_OFS_HOLD: prdata[15:0] <= hold_reg;
                    TSQ_OFS_BTE: prdata <= bte_reg;
                    TSQ_OFS_CNT: prdata <= {loop_reg[1], loop_reg[0]};
                    default: ;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    a_literal_locked: assert property (@(posedge clk) disable iff (!arst_n)
        busy && state_reg != TSQ_S_EXEC && wr &&
        paddr == TSQ_OFS_TGT + 8'h14 |=> $stable(tgt_reg[TSQ_LIT]))
        else $error("literal changed by write while busy");
    a_qptr_upper: assert property (@(posedge clk) disable iff (!arst_n)
        psel && !penable && paddr == TSQ_OFS_QPTR |=> prdata[31:5] == 27'h0)
        else $error("pointer upper bits not zero");
    a_strobe_val: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && cmd_reg[7:5] == 3'b001 |=>
        strobe_stb && strobe_out == {11'h000, $past(cmd_reg[4:0])})
        else $error("strobe value wrong");
    a_trig_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && cmd_reg[7:5] == 3'b100 |=>
        trig_out == (32'h1 << $past(cmd_reg[4:0])) ##1 trig_out == 32'h0)
        else $error("trigger pulse wrong");
    a_irq_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && op == TSQ_OP_IRQ && !opt[3] |=>
        irq_req == (8'h01 << $past(cmd_reg[2:0])))
        else $error("interrupt pulse wrong");
    a_rise_wait: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_WAIT && op == TSQ_OP_WHI && run_reg &&
        !(trig_in[opt] && !trig_prev_reg[opt]) |=> state_reg == TSQ_S_WAIT)
        else $error("rising wait released early");
    a_jump_load: assert property (@(posedge clk) disable iff (!arst_n)
        step_done && cmd_reg[7:5] == 3'b101 |=> qptr_reg == $past(tgt5))
        else $error("jump target not loaded");
    a_loop_fall: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && ljump && lat_lim |=>
        qptr_reg == $past(qptr_reg) + 5'h01 && loop_reg[$past(lsel)] == 16'h0)
        else $error("loop fall-through wrong");
    a_loop_take: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && ljump && !lat_lim |=>
        qptr_reg == $past(tgt5) &&
        loop_reg[$past(lsel)] == $past(loop_reg[lsel]) + 16'h0001)
        else $error("loop jump wrong");
    a_add_target: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && op == TSQ_OP_ADD && opt == 4'h5 |=>
        tgt_reg[TSQ_LIT] == $past(tgt_reg[TSQ_LIT]) + $past(adj_reg))
        else $error("add to literal wrong");
    a_adc_chan: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && op == TSQ_OP_CTRL && opt == TSQ_CO_SLIT |=>
        adc_chan_stb && adc_channel_select == $past(tgt_reg[TSQ_LIT][5:0]))
        else $error("channel select wrong");
    a_timer_wait: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_WAIT && op == TSQ_OP_CTRL && opt == TSQ_CO_T0 && run_reg &&
        tmr_reg != tgt_reg[2] |=> state_reg == TSQ_S_WAIT)
        else $error("timer wait released early");
    a_step_delay: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_DELAY && run_reg && dly_reg < tgt_reg[4] |=>
        state_reg == TSQ_S_DELAY)
        else $error("step delay ended early");
    a_bcast_mask: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == TSQ_S_EXEC && op == TSQ_OP_CTRL && opt == TSQ_CO_BCAST |=>
        trig_out == $past(bte_reg))
        else $error("broadcast triggers wrong");
endmodule

// ===== logic/tsq_pkg.sv
// Constants, register map and decode codes for the step queue sequencer
//------------------------------------------------------------------------
// Summary of operation
// - Literal register low six bits go to the ADC channel select output
// - Literal, pointer and queue ignore software writes while executing
// - Pointer is five bits; bits 31 to 5 read as zero
// - Sixteen queue words hold two steps each, odd step in high byte
// - Opcode in bits 7-4, option in 3-0; opcode 0 is control
// - Opcode 1 add options add the adjust register to a target
// - Copy options move the hold register into a target
// - Opcodes 001x put opcode bit 0 and option on the strobe
// - Opcode 0100 waits for a rising edge on the chosen input
// - Opcode 0101 waits for a falling edge on the chosen input
// - Opcode 0110 and reserved codes run as a no-operation
// - Opcode 0111 with options 0-7 raises the interrupt request chosen by the option
// - Opcodes 100x pulse one of thirty-two trigger outputs
// - Opcodes 101x load the pointer with the five-bit target
// - Loop jump with counter at limit clears the counter and advances the pointer
// - Loop jump below limit increments the counter and jumps
// - Opcodes 111x use loop counter 1 and its own limit
// - Add targets: loop limits, timer limits, delay limit, literal
// - Copy options 1000-1101 use the same six targets
// - Control: delay timer off/on, timer waits, software trigger waits
// - Control: limits or literal to strobe; 1111 broadcasts triggers
//------------------------------------------------------------------------
package tsq_pkg;
    // Target slots: loop limit 0/1, timer limit 0/1, delay limit, literal
    localparam int TSQ_NTGT = 6;
    localparam int TSQ_LIT = 5;
    localparam logic [7:0] TSQ_OFS_TGT = 8'h00; // Slot i at 4*i
    localparam logic [7:0] TSQ_OFS_QPTR = 8'h18;
    localparam logic [7:0] TSQ_OFS_CTRL = 8'h1c;
    localparam logic [7:0] TSQ_OFS_ADJ = 8'h20;
    localparam logic [7:0] TSQ_OFS_HOLD = 8'h24;
    localparam logic [7:0] TSQ_OFS_BTE = 8'h28;
    localparam logic [7:0] TSQ_OFS_CNT = 8'h2c;
    localparam logic [7:0] TSQ_OFS_QUE = 8'h40; // Word n at 0x40+4*n
    // Control register bits
    localparam int TSQ_CB_RUN = 0;
    localparam int TSQ_CB_SWT = 1;
    localparam int TSQ_CB_SDEN = 2;
    localparam int TSQ_CB_BUSY = 8;
    localparam logic [15:0] TSQ_RST16 = 16'h0000;
    localparam logic [31:0] TSQ_RST32 = 32'h0000_0000;
    // Opcodes
    localparam logic [3:0] TSQ_OP_CTRL = 4'h0;
    localparam logic [3:0] TSQ_OP_ADD = 4'h1;
    localparam logic [3:0] TSQ_OP_WHI = 4'h4;
    localparam logic [3:0] TSQ_OP_WLO = 4'h5;
    localparam logic [3:0] TSQ_OP_IRQ = 4'h7;
    // Control options
    localparam logic [3:0] TSQ_CO_SDOFF = 4'h2;
    localparam logic [3:0] TSQ_CO_SDON = 4'h6;
    localparam logic [3:0] TSQ_CO_T0 = 4'h8;
    localparam logic [3:0] TSQ_CO_T1 = 4'h9;
    localparam logic [3:0] TSQ_CO_SWL = 4'ha;
    localparam logic [3:0] TSQ_CO_SWE = 4'hb;
    localparam logic [3:0] TSQ_CO_SC0 = 4'hc;
    localparam logic [3:0] TSQ_CO_SC1 = 4'hd;
    localparam logic [3:0] TSQ_CO_SLIT = 4'he;
    localparam logic [3:0] TSQ_CO_BCAST = 4'hf;
    typedef enum logic [2:0] {
        TSQ_S_IDLE = 3'b000,
        TSQ_S_FETCH = 3'b001,
        TSQ_S_EXEC = 3'b010,
        TSQ_S_WAIT = 3'b011,
        TSQ_S_DELAY = 3'b100
    } tsq_state_t;
endpackage

// ===== sim/step_queue_command_decoder_bench.sv
// Self-checking bench: loads a step program over APB and checks its effects
module step_queue_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tsq_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, seed, bte;
    logic pready, pslverr, er;
    logic [15:0] trig_in, strobe_out, lit0, adj, hold, strb_first;
    logic [31:0] trig_out;
    logic [7:0] irq_req;
    logic strobe_stb, adc_chan_stb;
    logic [5:0] adc_channel_select;
    logic [15:0] prog [16];
    int err_total = 0;
    int cmp_count = 0;
    int n_trig, n_irq, n_other, n_adc, n_strb, i;
    //--------------------------------------------------------------------
    // Clock, design, peripheral model
    //--------------------------------------------------------------------
    always #2 clk = ~clk;
    tsq_core dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .trig_out(trig_out), .irq_req(irq_req),
        .strobe_out(strobe_out), .strobe_stb(strobe_stb),
        .adc_channel_select(adc_channel_select), .adc_chan_stb(adc_chan_stb));
    tsq_periph periph_u (.clk(clk), .arst_n(arst_n), .trig_in(trig_in), .trig_out(trig_out),
        .irq_req(irq_req), .n_trig(n_trig), .n_irq(n_irq), .n_other(n_other));
    // Count channel-select and strobe updates, keep the first strobe value
    always_ff @(posedge clk) begin
        n_adc <= !arst_n ? 0 : n_adc + int'(adc_chan_stb === 1'b1);
        n_strb <= !arst_n ? 0 : n_strb + int'(strobe_stb === 1'b1);
        if (strobe_stb === 1'b1 && n_strb == 0) begin
            strb_first <= strobe_out;
        end
    end
    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll the pointer until it shows p; a miss shows up in the compare
    task automatic poll_qptr(input logic [4:0] p);
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, TSQ_OFS_QPTR, 32'h0);
            if (rd === {27'h0, p}) break;
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, TSQ_OFS_TGT + 8'h14, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, TSQ_OFS_QPTR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        seed = xs(32'h301c5488);
        lit0 = seed[15:0];
        adj = seed[31:16];
        seed = xs(seed);
        hold = 16'(seed[1:0] % 3 + 1);
        bte = {1'b1, seed[30:2], 2'b01};
        // Steps 12-21: timer wait, software level wait, broadcast, reserved, delay on/off
        prog = '{16'h1815, 16'h733a, 16'h0e9f, 16'hc442, 16'h5260, 16'h73ac, 16'h081a,
            16'h0f0a, 16'h1778, 16'h061c, 16'h0200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4f00};
        for (i = 0; i < 16; i++) begin
            apb(1'b1, TSQ_OFS_QUE + 8'(4 * i), {16'h0, prog[i]});
        end
        apb(1'b0, TSQ_OFS_QUE + 8'h08, 32'h0);
        chk(rd, 32'h0000_0e9f);
        apb(1'b1, TSQ_OFS_QPTR, 32'hffff_ffe0);
        apb(1'b0, TSQ_OFS_QPTR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, TSQ_OFS_TGT + 8'h14, {16'h0, lit0});
        apb(1'b1, TSQ_OFS_ADJ, {16'h0, adj});
        apb(1'b1, TSQ_OFS_HOLD, {16'h0, hold});
        apb(1'b1, TSQ_OFS_BTE, bte);
        apb(1'b1, TSQ_OFS_CTRL, 32'h1);
        apb(1'b1, TSQ_OFS_TGT + 8'h14, 32'h0000_ffff);
        poll_qptr(5'h0e);
        apb(1'b0, TSQ_OFS_QPTR, 32'h0);
        chk(rd, 32'he);
        apb(1'b1, TSQ_OFS_CTRL, 32'h3);
        poll_qptr(5'h1f);
        chk(rd, 32'h1f);
        apb(1'b1, TSQ_OFS_QUE, 32'h0);
        apb(1'b0, TSQ_OFS_QUE, 32'h0);
        chk(rd, 32'h1815);
        apb(1'b1, TSQ_OFS_TGT + 8'h14, 32'h0000_ffff);
        apb(1'b0, TSQ_OFS_TGT + 8'h14, 32'h0);
        chk(rd, {16'h0, lit0 + adj});
        apb(1'b0, TSQ_OFS_TGT, 32'h0);
        chk(rd, {16'h0, hold});
        apb(1'b0, TSQ_OFS_TGT + 8'h08, 32'h0);
        chk(rd, {16'h0, hold});
        apb(1'b0, TSQ_OFS_TGT + 8'h10, 32'h0);
        chk(rd, {16'h0, hold});
        apb(1'b0, TSQ_OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0103);
        apb(1'b0, TSQ_OFS_CNT, 32'h0);
        chk(rd, 32'h0);
        chk({16'h0, strb_first}, 32'h1a);
        chk({16'h0, strobe_out}, {16'h0, lit0 + adj});
        chk(n_strb, hold + 2);
        chk({26'h0, adc_channel_select}, {26'h0, lit0[5:0] + adj[5:0]});
        chk(n_trig, hold + 2);
        chk(n_adc, hold + 1);
        chk(n_irq, 1);
        chk(n_other, 1);
        apb(1'b1, TSQ_OFS_CTRL, 32'h0);
        apb(1'b1, TSQ_OFS_TGT + 8'h14, 32'h0000_1234);
        apb(1'b0, TSQ_OFS_TGT + 8'h14, 32'h0);
        chk(rd, 32'h1234);
        end_of_test();
    end
endmodule

// ===== sim/tsq_periph.sv
// Model of the peripherals that feed trigger inputs and take sequencer pulses
module tsq_periph (
    input wire logic clk, // Sequencer clock
    input wire logic arst_n, // Async reset, active low
    output logic [15:0] trig_in, // Trigger inputs to the sequencer
    input wire logic [31:0] trig_out, // Trigger pulses from the sequencer
    input wire logic [7:0] irq_req, // Interrupt pulses from the sequencer
    output int n_trig, // Pulses seen on the top trigger output
    output int n_irq, // Pulses seen on interrupt 3
    output int n_other // Cycles with a pulse seen anywhere else
);
    timeunit 1ns;
    timeprecision 1ps;
    int div;
    // Square wave on input 2 only; input 15 never moves so a wait on it stalls
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div <= 0;
            trig_in <= 16'h0000;
        end else begin
            div <= div + 1;
            if (div % 16 == 15) begin
                trig_in[2] <= ~trig_in[2];
            end
        end
    end
    // Count the trigger and interrupt pulses the sequencer hands out, other pulses once per cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            n_trig <= 0;
            n_irq <= 0;
            n_other <= 0;
        end else begin
            n_trig <= n_trig + int'(trig_out[31] === 1'b1);
            n_irq <= n_irq + int'(irq_req[3] === 1'b1);
            if ((trig_out[30:0] !== 31'h0) || ({irq_req[7:4], irq_req[2:0]} !== 7'h00)) begin
                n_other <= n_other + 1;
            end
        end
    end
endmodule
